// ---- include/smc_defines.vh ----
/*
 sleep mode controller constants: register indices, field positions, reset
 values, mode codes and timing counts.
 assumes: included by the controller files by its bare name.
*/
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH

`define SMC_ADDR_W 4
`define SMC_DATA_W 8

// register offsets
`define SMC_REG_SLEEP_CTRL 4'h0
`define SMC_REG_STATUS 4'h1
`define SMC_REG_PWR_RED 4'h2
`define SMC_REG_WAKE_MASK 4'h3

// sleep control fields and register reset values
`define SMC_CTRL_ENABLE_BIT 0
`define SMC_CTRL_MODE_LSB 1
`define SMC_CTRL_MODE_MSB 3
`define SMC_CTRL_RESET 8'h00
`define SMC_PWR_RED_RESET 8'h00
`define SMC_WAKE_MASK_RESET 8'hFF

// mode codes
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STANDBY 3'h6
`define SMC_MODE_EXT_STANDBY 3'h7

// wake source bit positions
`define SMC_SRC_TWI_MATCH 0
`define SMC_SRC_PORT_ASYNC 1
`define SMC_SRC_USB_RESUME 2
`define SMC_SRC_RTC 3
`define SMC_NUM_SRC 8

// clock domain bits of the clock-run vector
`define SMC_CLK_CPU 0
`define SMC_CLK_NVM 1
`define SMC_CLK_PER 2
`define SMC_CLK_RTC 3
`define SMC_CLK_OSC 4
`define SMC_NUM_CLK 5

// wake halt: four cpu clocks
`define SMC_WAKE_HALT_CYCLES 4
// halt counter load: counts 3 down to 0, so four halted cycles
`define SMC_HALT_LOAD 3'h3
`define SMC_HALT_CNT_W 3

`endif

// ---- rtl/smc_sync.v ----
/*
 three flip-flop synchroniser for one asynchronous level; a change is taken
 once the second and third stages agree.
 assumes: ref_clk domain, asynchronous active-high reset.
*/
`timescale 1ns/10ps
module smc_sync
(
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // level
    input wire async_in,
    output reg sync_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                sync_out <= stage3;
        end
    end
endmodule

// ---- rtl/smc_sleep_ctrl.v ----
/*
 sleep mode controller: latches the sleep mode on the sleep instruction,
 stops clock domains per mode, qualifies wake sources per mode, holds the
 cpu four cycles after wake, and gates peripheral clocks from software.
 assumes: cpu and interrupt controller on ref_clk; async wake pins from
 outside the clock domain; register port with read data one cycle later.
*/
`timescale 1ns/10ps
`include "smc_defines.vh"

// Operation
// (R1) five sleep modes stop different clock sets
// (R2) sleep entered only from active on instruction
// (R3) wake runs isr then resumes after sleep
// (R4) higher priority pending interrupts served first
// (R5) cpu halted four cycles after wake
// (R6) registers and memory retained while sleeping
// (R7) reset during sleep does full restart
// (R8) idle stops cpu, nvm; programming completes
// (R9) any enabled interrupt wakes from idle
// (R10) power-down stops every clock including rtc; code keeps the nvm clock running if nvm is busy at entry
// (R11) power-down wakes on twi, port, usb only
// (R12) wake sources depend on selected mode
// (R13) reset or enabled peripheral interrupt wakes
// (R14) power reduction gates peripheral clocks, freezes
// (R15) gating active in active and idle
// (R16) software selects mode before sleep instruction
module smc_sleep_ctrl
(
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // register port
    input wire [`SMC_ADDR_W-1:0] reg_addr,
    input wire [`SMC_DATA_W-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [`SMC_DATA_W-1:0] reg_rdata,
    // cpu core
    input wire sleep_instr,
    input wire nvm_busy,
    output reg cpu_halt,
    output reg cpu_resume,
    // interrupt controller, same clock
    input wire [`SMC_NUM_SRC-1:0] irq_pending,
    // asynchronous wake pins
    input wire twi_match_pin,
    input wire port_async_pin,
    input wire usb_resume_pin,
    // clock controls
    output reg [`SMC_NUM_CLK-1:0] clk_run,
    output reg [`SMC_DATA_W-1:0] per_clk_en,
    // state
    output reg sleeping
);
    localparam ST_ACTIVE = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_HALT = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`SMC_DATA_W-1:0] sleep_ctrl;
    reg [`SMC_DATA_W-1:0] pwr_red;
    reg [`SMC_DATA_W-1:0] wake_mask;
    reg [2:0] mode;
    reg [2:0] next_mode;
    reg [`SMC_HALT_CNT_W-1:0] halt_cnt;
    reg [`SMC_HALT_CNT_W-1:0] next_halt_cnt;
    reg nvm_hold;
    reg next_nvm_hold;
    reg wake_seen;
    reg next_wake_seen;
    wire twi_sync;
    wire port_sync;
    wire usb_sync;
    wire [`SMC_NUM_SRC-1:0] src_all;
    wire [`SMC_NUM_SRC-1:0] src_allowed;
    wire wake;

    // pins cross into ref_clk through three stages each
    smc_sync u_sync_twi
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(twi_match_pin),
        .sync_out(twi_sync)
    );
    smc_sync u_sync_port
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(port_async_pin),
        .sync_out(port_sync)
    );
    smc_sync u_sync_usb
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(usb_resume_pin),
        .sync_out(usb_sync)
    );

    // which sources may wake from a given mode
    function [`SMC_NUM_SRC-1:0] wake_allow;
        input [2:0] m;
        begin
            case (m)
                `SMC_MODE_IDLE:
                    wake_allow = {`SMC_NUM_SRC{1'b1}}; // (R9)
                `SMC_MODE_PDOWN:
                    wake_allow = 8'h07; // (R11)
                `SMC_MODE_PSAVE,
                `SMC_MODE_EXT_STANDBY,
                `SMC_MODE_STANDBY:
                    wake_allow = 8'h0F;
                default:
                    wake_allow = 8'h07;
            endcase
        end
    endfunction

    // clock domains kept running in a given sleep mode
    function [`SMC_NUM_CLK-1:0] clk_keep;
        input [2:0] m;
        begin
            case (m)
                `SMC_MODE_IDLE:
                    clk_keep = 5'h1C; // (R8)
                `SMC_MODE_PDOWN:
                    clk_keep = 5'h00; // (R10)
                `SMC_MODE_PSAVE:
                    clk_keep = 5'h08;
                `SMC_MODE_STANDBY:
                    clk_keep = 5'h10;
                `SMC_MODE_EXT_STANDBY:
                    clk_keep = 5'h18;
                default:
                    clk_keep = 5'h00;
            endcase
        end
    endfunction

    assign src_all = {irq_pending[`SMC_NUM_SRC-1:3], usb_sync | irq_pending[2],
        port_sync | irq_pending[1], twi_sync | irq_pending[0]};
    // (R12) (R13)
    assign src_allowed = src_all & wake_mask & wake_allow(mode);
    assign wake = |src_allowed;

    always @*
    begin
        next_state = state;
        next_mode = mode;
        next_halt_cnt = halt_cnt;
        next_nvm_hold = nvm_hold;
        next_wake_seen = 1'b0;
        case (state)
            ST_ACTIVE:
            begin
                // (R2) (R16)
                if (sleep_instr && sleep_ctrl[`SMC_CTRL_ENABLE_BIT])
                begin
                    next_state = ST_SLEEP;
                    next_mode = sleep_ctrl[`SMC_CTRL_MODE_MSB:`SMC_CTRL_MODE_LSB];
                    next_nvm_hold = nvm_busy;
                end
            end
            ST_SLEEP:
            begin
                // ongoing programming keeps the nvm clock until it ends (R8)
                if (!nvm_busy)
                    next_nvm_hold = 1'b0;
                if (wake)
                begin
                    next_state = ST_HALT;
                    next_halt_cnt = `SMC_HALT_LOAD; // (R5)
                    next_wake_seen = 1'b1;
                end
            end
            ST_HALT:
            begin
                if (halt_cnt == {`SMC_HALT_CNT_W{1'b0}})
                    next_state = ST_ACTIVE;
                else
                    next_halt_cnt = halt_cnt - 1'b1;
            end
            default:
                next_state = ST_ACTIVE;
        endcase
    end

    // (R7) reset from any state returns to active via full reset
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_ACTIVE;
            mode <= `SMC_MODE_IDLE;
            halt_cnt <= {`SMC_HALT_CNT_W{1'b0}};
            nvm_hold <= 1'b0;
            wake_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            halt_cnt <= next_halt_cnt;
            nvm_hold <= next_nvm_hold;
            wake_seen <= next_wake_seen;
        end
    end

    // outputs registered; retention is implicit since no state is cleared on sleep (R6)
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cpu_halt <= 1'b0;
            cpu_resume <= 1'b0;
            sleeping <= 1'b0;
            clk_run <= {`SMC_NUM_CLK{1'b1}};
            per_clk_en <= {`SMC_DATA_W{1'b1}};
        end
        else
        begin
            cpu_halt <= (next_state != ST_ACTIVE); // (R5)
            // resume pulse lets the core take the pending interrupts in
            // priority order and return after the sleep instruction (R3) (R4)
            cpu_resume <= (state == ST_HALT) && (next_state == ST_ACTIVE);
            sleeping <= (next_state == ST_SLEEP);
            if (next_state == ST_SLEEP)
            begin
                clk_run <= clk_keep(next_mode); // (R1)
                if (next_nvm_hold)
                    clk_run[`SMC_CLK_NVM] <= 1'b1;
            end
            else
                clk_run <= {`SMC_NUM_CLK{1'b1}};
            // peripheral gating follows software in active and idle (R14) (R15)
            per_clk_en <= ~pwr_red;
        end
    end

    // register port
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sleep_ctrl <= `SMC_CTRL_RESET;
            pwr_red <= `SMC_PWR_RED_RESET;
            wake_mask <= `SMC_WAKE_MASK_RESET;
            reg_rdata <= {`SMC_DATA_W{1'b0}};
        end
        else
        begin
            if (reg_write)
            begin
                case (reg_addr)
                    `SMC_REG_SLEEP_CTRL:
                        sleep_ctrl <= {4'h0, reg_wdata[3:0]};
                    `SMC_REG_PWR_RED:
                        pwr_red <= reg_wdata; // (R14)
                    `SMC_REG_WAKE_MASK:
                        wake_mask <= reg_wdata;
                    default:
                        sleep_ctrl <= sleep_ctrl;
                endcase
            end
            if (reg_read)
            begin
                case (reg_addr)
                    `SMC_REG_SLEEP_CTRL:
                        reg_rdata <= sleep_ctrl;
                    `SMC_REG_STATUS:
                        reg_rdata <= {2'h0, wake_seen, state, mode};
                    `SMC_REG_PWR_RED:
                        reg_rdata <= pwr_red;
                    `SMC_REG_WAKE_MASK:
                        reg_rdata <= wake_mask;
                    default:
                        reg_rdata <= {`SMC_DATA_W{1'b0}};
                endcase
            end
            else
                reg_rdata <= {`SMC_DATA_W{1'b0}};
        end
    end
endmodule

// ---- tb/smc_core_model.sv ----
/*
 core and interrupt controller model.
 assumes: ref_clk domain; the bench commands sleeps and requests.
*/
`timescale 1ns/10ps
module smc_core_model
(
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // bench commands
    input wire do_sleep,
    input wire [7:0] irq_set,
    // controller side
    input wire cpu_halt,
    input wire cpu_resume,
    output reg sleep_instr,
    output reg [7:0] irq_pending
);
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sleep_instr <= 1'b0;
            irq_pending <= 8'h00;
        end
        else
        begin
            // a halted core cannot execute anything
            sleep_instr <= do_sleep & ~cpu_halt;
            // on resume all pending requests are cleared together in one cycle
            irq_pending <= cpu_resume ? 8'h00 : (irq_pending | irq_set);
        end
    end
endmodule

// ---- tb/smc_sleep_sva.sv ----
/*
 port checker for the sleep mode controller.
 assumes: bound to smc_sleep_ctrl, one clock domain.
*/
`timescale 1ns/10ps
module smc_sleep_sva
(
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // observed ports
    input wire reg_read,
    input wire reg_write,
    input wire [7:0] reg_rdata,
    input wire sleep_instr,
    input wire cpu_halt,
    input wire cpu_resume,
    input wire [4:0] clk_run,
    input wire [7:0] per_clk_en,
    input wire sleeping
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    entry_needs_instr_a: assert property (
        $rose(sleeping) |-> $past(sleep_instr)) else $error("sleep without instruction");
    sleep_halts_a: assert property (
        sleeping |-> cpu_halt) else $error("cpu runs while asleep");
    mode_clocks_a: assert property (
        sleeping |-> clk_run inside {5'h1C, 5'h1E, 5'h00, 5'h08, 5'h10, 5'h18})
        else $error("bad clock set in sleep");
    wake_clocks_a: assert property (
        $fell(sleeping) |-> clk_run == 5'h1F) else $error("clocks not back on wake");
    wake_halt_four_a: assert property (
        $fell(sleeping) |-> cpu_halt [*4] ##1 (!cpu_halt && cpu_resume))
        else $error("wake halt not four cycles");
    resume_pulse_a: assert property (
        cpu_resume |-> $past(cpu_halt) && !cpu_halt ##1 !cpu_resume)
        else $error("resume pulse malformed");
    gating_held_a: assert property (
        !$past(reg_write, 2) |-> $stable(per_clk_en)) else $error("gating changed alone");
    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside slot");
endmodule

bind smc_sleep_ctrl smc_sleep_sva chk_i
(
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_read(reg_read),
    .reg_write(reg_write),
    .reg_rdata(reg_rdata),
    .sleep_instr(sleep_instr),
    .cpu_halt(cpu_halt),
    .cpu_resume(cpu_resume),
    .clk_run(clk_run),
    .per_clk_en(per_clk_en),
    .sleeping(sleeping)
);

// ---- tb/test_sleep_mode_controller.sv ----
/*
 bench for the sleep mode controller.
 assumes: core model drives sleep and requests; 125 MHz clock.
*/
`timescale 1ns/10ps
`include "smc_defines.vh"
module test_sleep_mode_controller;
    reg ref_clk = 1'b0;
    reg reset = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg do_sleep = 1'b0;
    reg nvm_busy = 1'b0;
    reg [7:0] irq_set = 8'h00;
    reg [2:0] pins = 3'h0;
    wire [7:0] reg_rdata, per_clk_en, irq_pending;
    wire [4:0] clk_run;
    wire sleep_instr, cpu_halt, cpu_resume, sleeping;
    integer errors = 0;
    integer cmp_count = 0;
    integer i, n;
    // mode, request, pins {usb,port,twi}, clock set in sleep
    reg [18:0] rows [0:4];
    always #4 ref_clk = ~ref_clk;
    smc_sleep_ctrl uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep_instr(sleep_instr), .nvm_busy(nvm_busy),
        .cpu_halt(cpu_halt), .cpu_resume(cpu_resume), .irq_pending(irq_pending),
        .twi_match_pin(pins[0]), .port_async_pin(pins[1]), .usb_resume_pin(pins[2]),
        .clk_run(clk_run), .per_clk_en(per_clk_en), .sleeping(sleeping));
    smc_core_model core (.ref_clk(ref_clk), .reset(reset), .do_sleep(do_sleep),
        .irq_set(irq_set), .cpu_halt(cpu_halt), .cpu_resume(cpu_resume),
        .sleep_instr(sleep_instr), .irq_pending(irq_pending));
    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("[ERR] %s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge ref_clk);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge ref_clk);
            reg_read <= 1'b0;
            #1;
            chk("rdata", exp, reg_rdata);
        end
    endtask
    task slp(input [2:0] mode, input en);
        begin
            wr(`SMC_REG_SLEEP_CTRL, {4'h0, mode, en});
            do_sleep <= 1'b1;
            @(posedge ref_clk);
            do_sleep <= 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
        end
    endtask
    task wk(input [7:0] irq, input [2:0] p);
        begin
            @(posedge ref_clk);
            irq_set <= irq;
            pins <= p;
            @(posedge ref_clk);
            irq_set <= 8'h00;
            #1;
            n = 0;
            while (sleeping !== 1'b0 && n < 50)
            begin
                @(posedge ref_clk);
                #1;
                n = n + 1;
            end
            chk("wake clk", 8'h1F, clk_run);
            n = 0;
            while (cpu_resume !== 1'b1 && n < 10)
            begin
                @(posedge ref_clk);
                #1;
                n = n + 1;
            end
            chk("halt", 8'h04, n[7:0]);
            @(posedge ref_clk);
            pins <= 3'h0;
        end
    endtask
    task results;
        begin
            $display("errors %0d compares %0d", errors, cmp_count);
            if (errors == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial
    begin
        rows[0] = {`SMC_MODE_IDLE, 8'h80, 3'h0, 5'h1C};
        rows[1] = {`SMC_MODE_PDOWN, 8'h00, 3'h1, 5'h00};
        rows[2] = {`SMC_MODE_PSAVE, 8'h08, 3'h0, 5'h08};
        rows[3] = {`SMC_MODE_STANDBY, 8'h04, 3'h0, 5'h10};
        rows[4] = {`SMC_MODE_EXT_STANDBY, 8'h00, 3'h4, 5'h18};
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk("per_clk_en", 8'hFF, per_clk_en);
        rd(`SMC_REG_WAKE_MASK, 8'hFF);
        rd(4'hF, 8'h00);
        for (i = 0; i < 5; i = i + 1)
        begin
            slp(rows[i][18:16], 1'b1);
            chk("sleep clk", {3'h0, rows[i][4:0]}, clk_run);
            wk(rows[i][15:8], rows[i][7:5]);
        end
        slp(`SMC_MODE_PDOWN, 1'b0);
        chk("no enable", 8'h00, {7'h0, sleeping});
        slp(`SMC_MODE_PDOWN, 1'b1);
        irq_set <= 8'h08;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("rtc in pdown", 8'h01, {7'h0, sleeping});
        wk(8'h00, 3'h2);
        wr(`SMC_REG_PWR_RED, 8'h05);
        nvm_busy <= 1'b1;
        slp(`SMC_MODE_IDLE, 1'b1);
        chk("nvm run", 8'h1E, clk_run);
        chk("idle gate", 8'hFA, per_clk_en);
        nvm_busy <= 1'b0;
        wk(8'h01, 3'h0);
        slp(`SMC_MODE_PDOWN, 1'b1);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk("reset sleep", 8'h00, {7'h0, sleeping});
        chk("reset clk", 8'h1F, clk_run);
        rd(`SMC_REG_SLEEP_CTRL, 8'h00);
        rd(`SMC_REG_STATUS, 8'h00);
        results;
    end
    initial
    begin
        #40000;
        errors = errors + 1;
        results;
    end
endmodule
